// ===== dv/core_model.sv
// Core, oscillator and reset logic facing the watchdog unit.
// Assumes pclk from the bench; tick stands low between bursts.
`default_nettype none

module core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic short_reset_req,
  input wire logic stop_recovery_req,
  output logic wdt_osc_tick,
  output logic refresh_op,
  output logic [7:0] resets_seen,
  output logic [7:0] recoveries_seen
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle levels at time zero
  initial begin
    wdt_osc_tick = 1'b0;
    refresh_op = 1'b0;
  end

  ////////////////////////////////////////
  // Oscillator burst, three pclk high and three low
  task automatic osc(input int n);
    repeat (n) begin
      @(posedge pclk);
      wdt_osc_tick <= ~wdt_osc_tick;
      repeat (3) @(posedge pclk);
      wdt_osc_tick <= ~wdt_osc_tick;
      repeat (2) @(posedge pclk);
    end
    repeat (4) @(posedge pclk); // Let the last step land
  endtask

  // One refresh instruction
  task automatic refresh();
    @(posedge pclk);
    refresh_op <= ~refresh_op;
    @(posedge pclk);
    refresh_op <= ~refresh_op;
    repeat (2) @(posedge pclk);
  endtask

  // Reset and recovery logic counts requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resets_seen <= 8'h00;
      recoveries_seen <= 8'h00;
    end else begin
      resets_seen <= resets_seen + {7'h00, short_reset_req};
      recoveries_seen <= recoveries_seen + {7'h00, stop_recovery_req};
    end
  end
endmodule // core_model

`default_nettype wire

// ===== dv/watchdog_monitor.sv
// Checker for bus timing and time-out request pulses of the watchdog unit.
// Assumes binding to watchdog_timeout_unit; sees only its ports.
`default_nettype none

module watchdog_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic debug_mode,
  input wire logic stop_mode,
  input wire logic timeout_response_select,
  input wire logic short_reset_req,
  input wire logic stop_recovery_req
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////
  // Bus phases
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence

  ////////////////////////////////////////
  // Bus answers in the access cycle only
  ready_after_setup_a: assert property (setup_s |=> access_s)
    else $error("no ready after setup");
  ready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("error outside access");
  idle_data_a: assert property (!pready |-> prdata == 32'h00000000)
    else $error("read data outside access");
  // Time-out requests
  reset_pulse_a: assert property (short_reset_req |=> !short_reset_req)
    else $error("short reset longer than one cycle");
  recovery_pulse_a: assert property (stop_recovery_req |=> !stop_recovery_req)
    else $error("recovery longer than one cycle");
  reset_mode_only_a: assert property (
    short_reset_req |-> timeout_response_select && !stop_mode)
    else $error("short reset in wrong mode");
  recovery_in_stop_a: assert property (stop_recovery_req |-> stop_mode)
    else $error("recovery outside stop");
  debug_quiet_a: assert property (debug_mode [*4] |-> !short_reset_req && !stop_recovery_req)
    else $error("time-out during debug");
endmodule // watchdog_monitor

bind watchdog_timeout_unit watchdog_monitor u_watchdog_monitor (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .debug_mode(debug_mode),
  .stop_mode(stop_mode),
  .timeout_response_select(timeout_response_select),
  .short_reset_req(short_reset_req),
  .stop_recovery_req(stop_recovery_req)
);

`default_nettype wire

// ===== dv/watchdog_timeout_unit_tb.sv
// Bench for the watchdog unit: APB tasks and directed tests.
// Assumes core_model as far side and the bound checker.
`default_nettype none

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end

module watchdog_timeout_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic debug_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic opt = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic pready, pslverr, rerr, irq, short_reset_req, stop_recovery_req;
  logic wdt_osc_tick, refresh_op;
  logic [7:0] resets_seen, recoveries_seen;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;

  always #25 pclk = ~pclk;

  watchdog_timeout_unit u_watchdog_timeout_unit (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdt_osc_tick(wdt_osc_tick),
    .refresh_op(refresh_op), .debug_mode(debug_mode), .stop_mode(stop_mode),
    .timeout_response_select(opt), .irq(irq), .short_reset_req(short_reset_req),
    .stop_recovery_req(stop_recovery_req));

  core_model u_core_model (.pclk(pclk), .presetn(presetn),
    .short_reset_req(short_reset_req), .stop_recovery_req(stop_recovery_req),
    .wdt_osc_tick(wdt_osc_tick), .refresh_op(refresh_op),
    .resets_seen(resets_seen), .recoveries_seen(recoveries_seen));

  ////////////////////////////////////////
  // APB transfer: hold until pready at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    `CHK(rdat, e)
  endtask

  // Level of irq once the last write has landed
  task automatic irq_is(input logic e);
    repeat (3) @(posedge pclk);
    `CHK(irq, e)
  endtask

  // Unlock, then reload bytes in order
  task automatic prog(input logic [23:0] v);
    wr(wdt_pkg::ADDR_CTRL, 32'h00000055);
    wr(wdt_pkg::ADDR_CTRL, 32'h000000aa);
    wr(wdt_pkg::ADDR_RELOAD_UPPER, {24'h000000, v[23:16]});
    wr(wdt_pkg::ADDR_RELOAD_HIGH, {24'h000000, v[15:8]});
    wr(wdt_pkg::ADDR_RELOAD_LOW, {24'h000000, v[7:0]});
  endtask

  task automatic do_reset(input logic o);
    presetn <= 1'b0;
    opt <= o;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      complete_run();
    end
  end

  ////////////////////////////////////////
  // Directed tests
  initial begin
    do_reset(1'b0);
    chk(wdt_pkg::ADDR_RELOAD_LOW, 32'h000000ff);
    chk(wdt_pkg::ADDR_IRQ_MASK, 32'h00000000);
    wr(wdt_pkg::ADDR_RELOAD_UPPER, 32'h00000012);
    chk(wdt_pkg::ADDR_RELOAD_UPPER, 32'h000000ff);
    wr(wdt_pkg::ADDR_CTRL, 32'h00000055);
    wr(wdt_pkg::ADDR_CTRL, 32'h000000aa);
    chk(wdt_pkg::ADDR_CTRL, 32'h00000000);
    wr(wdt_pkg::ADDR_IRQ_MASK, 32'h00000000);
    wr(wdt_pkg::ADDR_RELOAD_UPPER, 32'h00000012);
    chk(wdt_pkg::ADDR_RELOAD_UPPER, 32'h000000ff);
    apb(1'b0, 8'h1c, 32'h00000000);
    `CHK(rerr, 1'b1)
    $display("test lock done");
    prog(24'h000006);
    chk(wdt_pkg::ADDR_RELOAD_LOW, 32'h00000006);
    wr(wdt_pkg::ADDR_CTRL, 32'h00000001);
    chk(wdt_pkg::ADDR_COUNT, 32'h00000006);
    wr(wdt_pkg::ADDR_IRQ_MASK, 32'h00000001);
    u_core_model.osc(5);
    chk(wdt_pkg::ADDR_COUNT, 32'h00000001);
    irq_is(1'b0);
    u_core_model.osc(1);
    irq_is(1'b1);
    chk(wdt_pkg::ADDR_CTRL, 32'h00000081);
    wr(wdt_pkg::ADDR_IRQ_MASK, 32'h00000000);
    irq_is(1'b0);
    wr(wdt_pkg::ADDR_IRQ_MASK, 32'h00000001);
    irq_is(1'b1);
    wr(wdt_pkg::ADDR_IRQ_STATUS, 32'h00000001);
    irq_is(1'b0);
    u_core_model.osc(1);
    chk(wdt_pkg::ADDR_COUNT, 32'h000fffff);
    u_core_model.refresh();
    chk(wdt_pkg::ADDR_COUNT, 32'h00000006);
    $display("test interrupt done");
    debug_mode <= 1'b1;
    u_core_model.osc(8);
    debug_mode <= 1'b0;
    chk(wdt_pkg::ADDR_COUNT, 32'h00000006);
    $display("test debug done");
    wr(wdt_pkg::ADDR_CTRL, 32'h00000081);
    wr(wdt_pkg::ADDR_IRQ_MASK, 32'h00000003);
    stop_mode <= 1'b1;
    u_core_model.osc(6);
    `CHK(recoveries_seen, 8'h01)
    chk(wdt_pkg::ADDR_CTRL, 32'h000000c1);
    chk(wdt_pkg::ADDR_IRQ_STATUS, 32'h00000003);
    irq_is(1'b1);
    stop_mode <= 1'b0;
    $display("test stop interrupt done");
    do_reset(1'b1);
    prog(24'h000006);
    wr(wdt_pkg::ADDR_CTRL, 32'h00000001);
    u_core_model.osc(6);
    `CHK(resets_seen, 8'h01)
    chk(wdt_pkg::ADDR_CTRL, 32'h00000083);
    chk(wdt_pkg::ADDR_COUNT, 32'h00000000);
    u_core_model.refresh();
    wr(wdt_pkg::ADDR_CTRL, 32'h00000083);
    stop_mode <= 1'b1;
    u_core_model.osc(6);
    `CHK(recoveries_seen, 8'h01)
    `CHK(resets_seen, 8'h01)
    chk(wdt_pkg::ADDR_CTRL, 32'h000000c3);
    stop_mode <= 1'b0;
    $display("test reset mode done");
    complete_run();
  end
endmodule // watchdog_timeout_unit_tb

`default_nettype wire

// ===== rtl/tick_sync.sv
// Two-flop synchroniser with a rising-edge pulse for the oscillator tick.
// Assumes the input is asynchronous to clk and slower than half of it.
`default_nettype none

module tick_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic rise_pulse
);

  logic meta_r;
  logic sync_r;
  logic hist_r;

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser chain; only sync_r reads meta_r
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      hist_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      hist_r <= sync_r;
    end
  end

  // One-cycle pulse on each rising oscillator edge
  assign rise_pulse = sync_r & ~hist_r;

endmodule // tick_sync

`default_nettype wire

// ===== rtl/watchdog_timeout_unit.sv
// Watchdog time-out unit: 24-bit down-counter, unlock sequence, APB registers.
// Assumes pclk from the system, an asynchronous oscillator tick pin, and
// refresh, stop and debug signals from core logic on pclk.
//
// Added by the designer: the placing of the registers and register access over APB.
`default_nettype none

// Summary of operation
// R1 - First enable loads counter, then counts down
// R2 - Refresh instruction reloads counter from reload value
// R3 - Debug mode refreshes counter continuously
// R4 - Zero count times out; option picks response
// R5 - Interrupt mode: raise request, set time-out flag
// R6 - After interrupt time-out counter wraps, keeps counting
// R7 - Interrupt mode in stop: recover, interrupt, flags
// R8 - Reset mode: short reset, set time-out flag
// R9 - Reset mode in stop: recover instead, set flags
// R10 - Reload bytes locked unless unlocked
// R11 - Software unlocks with 55h then AAh
// R12 - Unlock writes leave control bits unchanged
// R13 - Software writes upper, high, low in order
// R14 - Stray write relocks the sequence
// R15 - Software keeps reload between 4 and max
// R16 - Oscillator tick decrements, crossed into pclk safely
module watchdog_timeout_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wdt_osc_tick,
  input wire logic refresh_op,
  input wire logic debug_mode,
  input wire logic stop_mode,
  input wire logic timeout_response_select,
  output logic irq,
  output logic short_reset_req,
  output logic stop_recovery_req
);

  logic tick;
  logic setup_ph;
  logic wr_acc;
  logic wr_ctrl;
  logic wr_upper;
  logic wr_high;
  logic wr_low;
  logic is_key_first;
  logic is_key_second;
  logic mapped;
  logic resp_reset_r;
  logic resp_taken_r;
  logic enable_r;
  logic enable_d_r;
  logic timeout_flag_r;
  logic stop_flag_r;
  logic [7:0] reload_upper_r;
  logic [7:0] reload_high_r;
  logic [7:0] reload_low_r;
  logic [23:0] count_r;
  logic [23:0] count_nxt;
  logic [23:0] reload_val;
  logic load_req;
  wdt_pkg::wdt_event_type evt_nxt;
  logic [1:0] irq_status_r;
  logic [1:0] irq_mask_r;
  logic [1:0] irq_set;
  logic [31:0] rd_nxt;
  wdt_pkg::lock_state_type lock_r;
  wdt_pkg::lock_state_type lock_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator tick crossing into pclk
  tick_sync u_tick_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(wdt_osc_tick),
    .rise_pulse(tick)
  ); // R16

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; answer one cycle after setup, writes land at the access edge
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite;
  assign wr_ctrl = wr_acc && (paddr == wdt_pkg::ADDR_CTRL);
  assign wr_upper = wr_acc && (paddr == wdt_pkg::ADDR_RELOAD_UPPER);
  assign wr_high = wr_acc && (paddr == wdt_pkg::ADDR_RELOAD_HIGH);
  assign wr_low = wr_acc && (paddr == wdt_pkg::ADDR_RELOAD_LOW);
  assign is_key_first = (pwdata[7:0] == wdt_pkg::UNLOCK_KEY_FIRST);
  assign is_key_second = (pwdata[7:0] == wdt_pkg::UNLOCK_KEY_SECOND);
  assign mapped = (paddr == wdt_pkg::ADDR_CTRL) || (paddr == wdt_pkg::ADDR_RELOAD_UPPER) ||
                  (paddr == wdt_pkg::ADDR_RELOAD_HIGH) || (paddr == wdt_pkg::ADDR_RELOAD_LOW) ||
                  (paddr == wdt_pkg::ADDR_COUNT) || (paddr == wdt_pkg::ADDR_IRQ_STATUS) ||
                  (paddr == wdt_pkg::ADDR_IRQ_MASK);

  // Read mux
  always_comb begin
    rd_nxt = 32'h00000000;
    unique case (paddr)
      wdt_pkg::ADDR_CTRL: begin
        rd_nxt[wdt_pkg::CTRL_ENABLE_BIT] = enable_r;
        rd_nxt[wdt_pkg::CTRL_RESP_BIT] = resp_reset_r;
        rd_nxt[wdt_pkg::CTRL_STOP_BIT] = stop_flag_r;
        rd_nxt[wdt_pkg::CTRL_TIMEOUT_BIT] = timeout_flag_r;
      end
      wdt_pkg::ADDR_RELOAD_UPPER: rd_nxt[7:0] = reload_upper_r;
      wdt_pkg::ADDR_RELOAD_HIGH: rd_nxt[7:0] = reload_high_r;
      wdt_pkg::ADDR_RELOAD_LOW: rd_nxt[7:0] = reload_low_r;
      wdt_pkg::ADDR_COUNT: rd_nxt[23:0] = count_r;
      wdt_pkg::ADDR_IRQ_STATUS: rd_nxt[1:0] = irq_status_r;
      wdt_pkg::ADDR_IRQ_MASK: rd_nxt[1:0] = irq_mask_r;
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~mapped;
      prdata <= (setup_ph && !pwrite) ? rd_nxt : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock state machine for the reload bytes
  always_comb begin
    lock_nxt = lock_r;
    if (wr_acc) begin
      lock_nxt = wdt_pkg::LOCK_LOCKED; // R14
      unique case (lock_r)
        wdt_pkg::LOCK_LOCKED: begin
          if (wr_ctrl && is_key_first) begin
            lock_nxt = wdt_pkg::LOCK_GOT_FIRST;
          end
        end
        wdt_pkg::LOCK_GOT_FIRST: begin
          if (wr_ctrl && is_key_second) begin
            lock_nxt = wdt_pkg::LOCK_WANT_UPPER;
          end
        end
        wdt_pkg::LOCK_WANT_UPPER: begin
          if (wr_upper) begin
            lock_nxt = wdt_pkg::LOCK_WANT_HIGH;
          end
        end
        wdt_pkg::LOCK_WANT_HIGH: begin
          if (wr_high) begin
            lock_nxt = wdt_pkg::LOCK_WANT_LOW;
          end
        end
        wdt_pkg::LOCK_WANT_LOW: lock_nxt = wdt_pkg::LOCK_LOCKED;
        default: lock_nxt = wdt_pkg::LOCK_LOCKED;
      endcase
      // A first key restarts the sequence, except right after a first key, where it relocks
      if (wr_ctrl && is_key_first && lock_r != wdt_pkg::LOCK_GOT_FIRST) begin
        lock_nxt = wdt_pkg::LOCK_GOT_FIRST;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_r <= wdt_pkg::LOCK_LOCKED;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  // Reload bytes, writable only at their step of the sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_upper_r <= wdt_pkg::RELOAD_UPPER_RST;
      reload_high_r <= wdt_pkg::RELOAD_HIGH_RST;
      reload_low_r <= wdt_pkg::RELOAD_LOW_RST;
    end else begin
      if (wr_upper && lock_r == wdt_pkg::LOCK_WANT_UPPER) begin
        reload_upper_r <= pwdata[7:0]; // R10
      end
      if (wr_high && lock_r == wdt_pkg::LOCK_WANT_HIGH) begin
        reload_high_r <= pwdata[7:0]; // R10
      end
      if (wr_low && lock_r == wdt_pkg::LOCK_WANT_LOW) begin
        reload_low_r <= pwdata[7:0]; // R10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response option caught once after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_reset_r <= 1'b0;
      resp_taken_r <= 1'b0;
    end else if (!resp_taken_r) begin
      resp_reset_r <= timeout_response_select; // R4
      resp_taken_r <= 1'b1;
    end
  end

  // Enable bit; key writes leave control unchanged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= 1'b0;
      enable_d_r <= 1'b0;
    end else begin
      enable_d_r <= enable_r;
      if (wr_ctrl && !is_key_first && !is_key_second) begin // R12
        enable_r <= pwdata[wdt_pkg::CTRL_ENABLE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Down-counter
  assign reload_val = {reload_upper_r, reload_high_r, reload_low_r};
  assign load_req = (enable_r & ~enable_d_r) | refresh_op | debug_mode; // R1 R2 R3

  always_comb begin
    count_nxt = count_r;
    evt_nxt = '0;
    if (enable_r) begin
      if (load_req) begin
        count_nxt = reload_val; // R1 R2 R3
      end else if (tick) begin // R16
        if (count_r == wdt_pkg::COUNT_ONE) begin
          count_nxt = wdt_pkg::COUNT_ZERO; // R4
          evt_nxt.timeout = 1'b1;
          evt_nxt.stop_rec = stop_mode; // R7 R9
        end else if (count_r == wdt_pkg::COUNT_ZERO) begin
          if (!resp_reset_r) begin
            count_nxt = wdt_pkg::COUNT_WRAP; // R6
          end
        end else begin
          count_nxt = count_r - wdt_pkg::COUNT_ONE; // R1
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= wdt_pkg::COUNT_ZERO;
    end else begin
      count_r <= count_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags in the control register; set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag_r <= 1'b0;
      stop_flag_r <= 1'b0;
    end else begin
      if (evt_nxt.timeout) begin
        timeout_flag_r <= 1'b1; // R5 R8
      end else if (wr_ctrl && !is_key_first && !is_key_second &&
                   pwdata[wdt_pkg::CTRL_TIMEOUT_BIT]) begin
        timeout_flag_r <= 1'b0;
      end
      if (evt_nxt.stop_rec) begin
        stop_flag_r <= 1'b1; // R7 R9
      end else if (wr_ctrl && !is_key_first && !is_key_second &&
                   pwdata[wdt_pkg::CTRL_STOP_BIT]) begin
        stop_flag_r <= 1'b0;
      end
    end
  end

  // Response outputs: short reset or stop recovery pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_reset_req <= 1'b0;
      stop_recovery_req <= 1'b0;
    end else begin
      short_reset_req <= evt_nxt.timeout & resp_reset_r & ~evt_nxt.stop_rec; // R8
      stop_recovery_req <= evt_nxt.stop_rec; // R7 R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and level output
  assign irq_set[wdt_pkg::IRQ_TIMEOUT_BIT] = evt_nxt.timeout & ~resp_reset_r; // R5 R7
  assign irq_set[wdt_pkg::IRQ_STOP_REC_BIT] = evt_nxt.stop_rec;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= 2'h0;
      irq_mask_r <= wdt_pkg::IRQ_MASK_RST;
    end else begin
      if (wr_acc && paddr == wdt_pkg::ADDR_IRQ_STATUS) begin
        irq_status_r <= (irq_status_r & ~pwdata[1:0]) | irq_set;
      end else begin
        irq_status_r <= irq_status_r | irq_set;
      end
      if (wr_acc && paddr == wdt_pkg::ADDR_IRQ_MASK) begin
        irq_mask_r <= pwdata[1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_r & irq_mask_r); // R5
    end
  end

endmodule // watchdog_timeout_unit

`default_nettype wire

// ===== rtl/wdt_pkg.sv
// Shared constants and types for the watchdog time-out unit.
// Assumes a 32-bit APB slave port with one register per aligned word.
`default_nettype none

package wdt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RELOAD_UPPER = 8'h04;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h08;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h0c;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_RESP_BIT = 1;
  localparam int CTRL_STOP_BIT = 6;
  localparam int CTRL_TIMEOUT_BIT = 7;

  // Interrupt status and mask fields
  localparam int IRQ_TIMEOUT_BIT = 0;
  localparam int IRQ_STOP_REC_BIT = 1;
  localparam int IRQ_WIDTH = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Unlock keys written to the control address
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;

  // Counter values
  localparam int COUNT_WIDTH = 24;
  localparam logic [23:0] COUNT_ZERO = 24'h000000;
  localparam logic [23:0] COUNT_ONE = 24'h000001;
  localparam logic [23:0] COUNT_WRAP = 24'h0fffff;

  // Reset values
  localparam logic [7:0] RELOAD_UPPER_RST = 8'hff;
  localparam logic [7:0] RELOAD_HIGH_RST = 8'hff;
  localparam logic [7:0] RELOAD_LOW_RST = 8'hff;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Lock state machine
  typedef enum logic [2:0] {
    LOCK_LOCKED = 3'b000,
    LOCK_GOT_FIRST = 3'b001,
    LOCK_WANT_UPPER = 3'b010,
    LOCK_WANT_HIGH = 3'b011,
    LOCK_WANT_LOW = 3'b100
  } lock_state_type;

  // Time-out event group raised by the counter
  typedef struct packed {
    logic stop_rec;
    logic timeout;
  } wdt_event_type;

endpackage : wdt_pkg

`default_nettype wire
